// file: verilog/usb_cfg_pkg.sv
/*
 * Constants for the USB function configuration and legacy keyboard trap block:
 * configuration offsets, field positions, reset values and keyboard port codes.
 * Assumes byte offsets into configuration space, reached as aligned dwords.
 */
package usb_cfg_pkg;

	// ------------------------------------------------------------
	// configuration offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] BASE_OFS = 8'h20;
	localparam logic [7:0] ILINE_OFS = 8'h3C;
	localparam logic [7:0] IPIN_OFS = 8'h3D;
	localparam logic [7:0] REL_OFS = 8'h60;
	localparam logic [7:0] MISC_OFS = 8'h6A;
	localparam logic [7:0] LEG_OFS = 8'hC0;

	// ------------------------------------------------------------
	// reset and fixed values
	// ------------------------------------------------------------
	localparam logic [7:0] ILINE_RST = 8'h00;
	localparam logic [7:0] IPIN_VAL = 8'h04;
	localparam logic [7:0] REL_PRE_ONE = 8'h00;
	localparam logic [7:0] REL_ONE = 8'h10;
	localparam logic [10:0] BASE_RST = 11'h000;
	localparam logic MISC_CLK_RST = 1'b1;
	localparam logic [15:0] LEG_RST = 16'h2000;

	// ------------------------------------------------------------
	// field positions and masks
	// ------------------------------------------------------------
	localparam int BASE_LSB = 5;
	localparam int BASE_MSB = 15;
	localparam int BASE_KIND_BIT = 0;
	localparam int MISC_CLK_BIT = 0;
	localparam int LEG_END = 15;
	localparam int LEG_ROUTE = 13;
	localparam int LEG_USB_ACT = 12;
	localparam int LEG_SMI_END_EN = 7;
	localparam int LEG_BUSY = 6;
	localparam int LEG_PT_EN = 5;
	localparam int LEG_USB_SMI_EN = 4;
	localparam int LEG_TRAP_LSB = 8;
	localparam logic [15:0] LEG_CTL_MASK = 16'h20BF;
	localparam logic [15:0] LEG_W1C_MASK = 16'h8F00;

	// ------------------------------------------------------------
	// keyboard controller ports and sequence codes
	// ------------------------------------------------------------
	localparam logic [15:0] CMD_PORT = 16'h0064;
	localparam logic [15:0] DATA_PORT = 16'h0060;
	localparam logic [7:0] CMD_GATE = 8'hD1;
	localparam logic [7:0] CMD_END = 8'hFF;
	localparam int GATE_DATA_BIT = 1;

	function automatic logic [5:0] cfg_dw(input logic [7:0] a);
		return a[7:2];
	endfunction : cfg_dw

	function automatic logic [4:0] lane_sh(input logic [7:0] a);
		return {a[1:0], 3'b000};
	endfunction : lane_sh

endpackage : usb_cfg_pkg

// file: verilog/passthru_if.sv
/*
 * Carries keyboard port accesses to the gate pass-through tracker and its verdict back.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface passthru_if;
	logic acc;
	logic wr;
	logic is_cmd;
	logic is_data;
	logic [7:0] wdata;
	logic enable;
	logic absorb;
	logic busy;
	logic done;
	logic gate;

	modport owner (output acc, wr, is_cmd, is_data, wdata, enable,
		input absorb, busy, done, gate);
	modport tracker (input acc, wr, is_cmd, is_data, wdata, enable,
		output absorb, busy, done, gate);
endinterface : passthru_if

// file: verilog/passthru_tracker.sv
/*
 * Follows the address-line-20 gate pass-through command sequence on the keyboard ports.
 * Assumes accesses arrive as single-cycle strobes qualified by the clock enable.
 */
`timescale 1ns/1ns
module passthru_tracker
	import usb_cfg_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// sequence traffic
	passthru_if.tracker pt
);

	// ------------------------------------------------------------
	// sequence state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CMD = 3'b010,
		ST_DATA = 3'b100
	} pt_state_t;

	pt_state_t st_r, st_nxt;
	logic gate_r, gate_nxt;
	logic done_r, done_nxt;
	logic cmd_w, cmd_r, data_w;

	assign cmd_w = pt.acc && pt.wr && pt.is_cmd;
	assign cmd_r = pt.acc && !pt.wr && pt.is_cmd;
	assign data_w = pt.acc && pt.wr && pt.is_data;

	always_comb
	begin
		st_nxt = st_r;
		gate_nxt = gate_r;
		done_nxt = 1'b0;
		pt.absorb = 1'b0;
		if (!pt.enable)
		begin
			st_nxt = ST_IDLE;
		end
		else if (pt.acc && (pt.is_cmd || pt.is_data))
		begin
			// any access off the expected path drops back to plain trapping
			st_nxt = ST_IDLE;
			unique case (st_r)
				ST_IDLE:
				begin
					if (cmd_w && pt.wdata == CMD_GATE)
					begin
						st_nxt = ST_CMD;
						pt.absorb = 1'b1;
					end
				end
				ST_CMD:
				begin
					if (cmd_w && pt.wdata == CMD_GATE)
					begin
						st_nxt = ST_CMD;
						pt.absorb = 1'b1;
					end
					else if (data_w)
					begin
						st_nxt = ST_DATA;
						gate_nxt = pt.wdata[GATE_DATA_BIT];
						pt.absorb = 1'b1;
					end
				end
				ST_DATA:
				begin
					if (cmd_r)
					begin
						st_nxt = ST_DATA;
						pt.absorb = 1'b1;
					end
					else if (cmd_w && pt.wdata == CMD_END)
					begin
						pt.absorb = 1'b1;
						done_nxt = 1'b1;
					end
				end
				default:
				begin
					st_nxt = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			st_r <= ST_IDLE;
			gate_r <= 1'b0;
			done_r <= 1'b0;
		end
		else if (i_ce)
		begin
			st_r <= st_nxt;
			gate_r <= gate_nxt;
			done_r <= done_nxt;
		end
	end

	assign pt.busy = (st_r != ST_IDLE);
	assign pt.done = done_r;
	assign pt.gate = gate_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_end_write;
		i_ce && pt.enable && st_r == ST_DATA && cmd_w && pt.wdata == CMD_END;
	endsequence

	chk_abandon_on_disable: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && !pt.enable) |=> !pt.busy)
		else $error("sequence kept running after pass-through was disabled");

	chk_end_pulse_once: assert property (@(posedge i_clk) disable iff (i_rst)
		s_end_write |=> (pt.done && !pt.busy) ##1 (!pt.done || !$past(i_ce)))
		else $error("sequence end did not give exactly one done pulse");

endmodule : passthru_tracker

// file: verilog/usb_function_config.sv
/*
 * Configuration registers of the USB host function and its legacy keyboard trap logic.
 * Assumes a configuration-cycle port with byte address (bits 7..2 pick the dword) and byte enables, and an
 * I/O strobe port on which keyboard accesses and window decoding are seen.
 */
`timescale 1ns/1ns

module usb_function_config
	import usb_cfg_pkg::*;
#(
	parameter logic [7:0] SPEC_RELEASE = REL_PRE_ONE
)
(
	// clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// configuration cycles
	input wire logic i_cfg_wr,
	input wire logic i_cfg_rd,
	input wire logic [7:0] i_cfg_addr,
	input wire logic [3:0] i_cfg_be,
	input wire logic [31:0] i_cfg_wdata,
	output logic [31:0] o_cfg_rdata,
	// I/O cycles
	input wire logic i_io_valid,
	input wire logic i_io_wr,
	input wire logic [15:0] i_io_addr,
	input wire logic [7:0] i_io_wdata,
	output logic o_usb_win_hit,
	output logic o_io_trap,
	// interrupts and side outputs
	input wire logic i_usb_irq,
	input wire logic i_shared_pci_irq_fourth,
	output logic o_shared_pci_irq_fourth,
	output logic o_sys_mgmt_irq_n,
	output logic o_usb_clk_48m_sel,
	output logic o_addr_line20_gate
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	passthru_if pv ();

	logic [10:0] base_r, base_nxt;
	logic [7:0] iline_r, iline_nxt;
	logic clk_sel_r, clk_sel_nxt;
	logic [15:0] ctl_r, ctl_nxt;
	logic [15:0] sticky_r, sticky_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [2:0] pin_sh_r, pin_sh_nxt;
	logic pin_r, pin_nxt;
	logic pirq_r, pirq_nxt;
	logic smi_r, smi_nxt;

	logic [5:0] dw;
	logic [15:0] leg_wm;
	logic [15:0] leg_set;
	logic [3:0] trap_ev;
	logic is_cmd, is_data, kb_acc;
	logic [31:0] rd_mux;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	assign dw = cfg_dw(i_cfg_addr);
	assign is_cmd = (i_io_addr == CMD_PORT);
	assign is_data = (i_io_addr == DATA_PORT);
	assign kb_acc = i_io_valid && (is_cmd || is_data);

	// only accesses the tracker did not claim count as traps
	assign trap_ev = {4{kb_acc && !pv.absorb}} & {
		i_io_wr && is_cmd, !i_io_wr && is_cmd, i_io_wr && is_data, !i_io_wr && is_data};

	assign pv.acc = i_io_valid && i_ce;
	assign pv.wr = i_io_wr;
	assign pv.is_cmd = is_cmd;
	assign pv.is_data = is_data;
	assign pv.wdata = i_io_wdata;
	assign pv.enable = ctl_r[LEG_PT_EN];

	passthru_tracker u_tracker (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.pt(pv)
	);

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (dw == cfg_dw(BASE_OFS))
		begin
			// upper half and bits 4..1 stay zero, bit 0 marks I/O space
			rd_mux[BASE_MSB:BASE_LSB] = base_r;
			rd_mux[BASE_KIND_BIT] = 1'b1;
		end
		else if (dw == cfg_dw(ILINE_OFS))
		begin
			rd_mux = (32'(iline_r) << lane_sh(ILINE_OFS))
				| (32'(IPIN_VAL) << lane_sh(IPIN_OFS));
		end
		else if (dw == cfg_dw(REL_OFS))
		begin
			rd_mux = 32'(SPEC_RELEASE) << lane_sh(REL_OFS);
		end
		else if (dw == cfg_dw(MISC_OFS))
		begin
			rd_mux = 32'(clk_sel_r) << lane_sh(MISC_OFS);
		end
		else if (dw == cfg_dw(LEG_OFS))
		begin
			rd_mux[15:0] = (ctl_r & LEG_CTL_MASK) | sticky_r;
			rd_mux[LEG_USB_ACT] = i_usb_irq;
			rd_mux[LEG_BUSY] = pv.busy;
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		base_nxt = base_r;
		iline_nxt = iline_r;
		clk_sel_nxt = clk_sel_r;
		ctl_nxt = ctl_r;
		leg_wm = 16'h0000;
		if (i_cfg_wr && dw == cfg_dw(BASE_OFS))
		begin
			if (i_cfg_be[0])
			begin
				base_nxt[2:0] = i_cfg_wdata[7:BASE_LSB];
			end
			if (i_cfg_be[1])
			begin
				base_nxt[10:3] = i_cfg_wdata[BASE_MSB:8];
			end
		end
		if (i_cfg_wr && dw == cfg_dw(ILINE_OFS) && i_cfg_be[ILINE_OFS[1:0]])
		begin
			iline_nxt = 8'(i_cfg_wdata >> lane_sh(ILINE_OFS));
		end
		if (i_cfg_wr && dw == cfg_dw(MISC_OFS) && i_cfg_be[MISC_OFS[1:0]])
		begin
			clk_sel_nxt = i_cfg_wdata[32'(lane_sh(MISC_OFS)) + MISC_CLK_BIT];
		end
		if (i_cfg_wr && dw == cfg_dw(LEG_OFS))
		begin
			leg_wm = {{8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
		end
		ctl_nxt = (ctl_r & ~(leg_wm & LEG_CTL_MASK))
			| (i_cfg_wdata[15:0] & leg_wm & LEG_CTL_MASK);

		// a flag raised in the same cycle as its clear survives
		leg_set = 16'h0000;
		leg_set[LEG_END] = pv.done;
		leg_set[LEG_TRAP_LSB +: 4] = trap_ev;
		sticky_nxt = (sticky_r & ~(i_cfg_wdata[15:0] & leg_wm & LEG_W1C_MASK)) | leg_set;

		rdata_nxt = i_cfg_rd ? rd_mux : rdata_r;

		// raw pin only feeds the next stage; value moves once stages 2 and 3 agree
		pin_sh_nxt = {pin_sh_r[1:0], i_shared_pci_irq_fourth};
		pin_nxt = (pin_sh_r[1] == pin_sh_r[2]) ? pin_sh_r[2] : pin_r;
		pirq_nxt = pin_r | (i_usb_irq & ctl_r[LEG_ROUTE]);

		// held off while a sequence runs so a mid-sequence USB event is served later
		smi_nxt = !pv.busy && |({sticky_r[LEG_END], i_usb_irq, sticky_r[11:8]}
			& {ctl_r[LEG_SMI_END_EN], ctl_r[LEG_USB_SMI_EN], ctl_r[3:0]});
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			base_r <= BASE_RST;
			iline_r <= ILINE_RST;
			clk_sel_r <= MISC_CLK_RST;
			ctl_r <= LEG_RST;
			sticky_r <= 16'h0000;
			rdata_r <= 32'h0000_0000;
			pin_sh_r <= 3'h0;
			pin_r <= 1'b0;
			pirq_r <= 1'b0;
			smi_r <= 1'b0;
		end
		else if (i_ce)
		begin
			base_r <= base_nxt;
			iline_r <= iline_nxt;
			clk_sel_r <= clk_sel_nxt;
			ctl_r <= ctl_nxt;
			sticky_r <= sticky_nxt;
			rdata_r <= rdata_nxt;
			pin_sh_r <= pin_sh_nxt;
			pin_r <= pin_nxt;
			pirq_r <= pirq_nxt;
			smi_r <= smi_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_cfg_rdata = rdata_r;
	assign o_usb_win_hit = i_io_valid && (i_io_addr[BASE_MSB:BASE_LSB] == base_r);
	assign o_io_trap = |(trap_ev & ctl_r[3:0]);
	assign o_shared_pci_irq_fourth = pirq_r;
	assign o_sys_mgmt_irq_n = !smi_r;
	assign o_usb_clk_48m_sel = clk_sel_r;
	assign o_addr_line20_gate = pv.gate;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// write-data bit that lands in the clock select, for the check below
	logic misc_wbit;
	assign misc_wbit = i_cfg_wdata[32'(lane_sh(MISC_OFS)) + MISC_CLK_BIT];

	sequence s_base_read;
		i_ce && i_cfg_rd && dw == cfg_dw(BASE_OFS);
	endsequence

	sequence s_cmd_write_trapped;
		i_ce && i_io_valid && i_io_wr && is_cmd && !pv.absorb;
	endsequence

	chk_base_fixed_bits: assert property (@(posedge i_clk) disable iff (i_rst)
		s_base_read |=> (o_cfg_rdata[31:16] == 16'h0000 && o_cfg_rdata[4:1] == 4'h0
			&& o_cfg_rdata[0]))
		else $error("base register fixed bits read wrong");

	chk_window_decode: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_io_valid && i_io_addr[BASE_MSB:BASE_LSB] != base_r) |-> !o_usb_win_hit)
		else $error("window hit outside programmed base");

	chk_pin_reads_const: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && i_cfg_rd && dw == cfg_dw(IPIN_OFS)) |=> o_cfg_rdata[15:8] == IPIN_VAL)
		else $error("interrupt pin byte not 04h");

	chk_irq_routing: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && i_usb_irq && ctl_r[LEG_ROUTE]) |=> o_shared_pci_irq_fourth)
		else $error("routed USB interrupt missing on shared line");

	chk_clock_select: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && i_cfg_wr && dw == cfg_dw(MISC_OFS) && i_cfg_be[MISC_OFS[1:0]])
		|=> o_usb_clk_48m_sel == $past(misc_wbit))
		else $error("clock select output does not follow its bit");

	chk_end_flag_sets: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && pv.done) |=> sticky_r[LEG_END])
		else $error("end flag not set after sequence end");

	chk_cmd_write_flag: assert property (@(posedge i_clk) disable iff (i_rst)
		s_cmd_write_trapped |=> sticky_r[LEG_TRAP_LSB + 3])
		else $error("port 64h write flag not set");

	chk_absorbed_no_flag: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && pv.absorb && sticky_r[11:8] == 4'h0 && !i_cfg_wr) |=> sticky_r[11:8] == 4'h0)
		else $error("sequence access set a trap flag");

	chk_smi_held: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_ce && !pv.busy && (sticky_r[11:8] & ctl_r[3:0]) != 4'h0) |=> !o_sys_mgmt_irq_n)
		else $error("enabled trap flag did not raise SMI");

	sequence s_leg_read;
		i_ce && i_cfg_rd && dw == cfg_dw(LEG_OFS);
	endsequence

	chk_status_live: assert property (@(posedge i_clk) disable iff (i_rst)
		s_leg_read |=> o_cfg_rdata[LEG_USB_ACT] == $past(i_usb_irq))
		else $error("USB interrupt status bit does not follow the interrupt");

	chk_trap_on_enable: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_io_valid && i_io_wr && is_cmd && !pv.absorb && ctl_r[3]) |-> o_io_trap)
		else $error("enabled port 64h write did not trap");

endmodule : usb_function_config

// file: dv/pci_host_model.sv
/*
 * Host bus master model: issues configuration cycles and keyboard-port I/O cycles.
 * Assumes config read data is registered on the edge that takes the read.
 */
`timescale 1ns/1ns
module pci_host_model
(
	// clock
	input wire logic i_clk,
	// configuration cycles
	output logic o_cfg_wr,
	output logic o_cfg_rd,
	output logic [7:0] o_cfg_addr,
	output logic [3:0] o_cfg_be,
	output logic [31:0] o_cfg_wdata,
	input wire logic [31:0] i_cfg_rdata,
	// I/O cycles
	output logic o_io_valid,
	output logic o_io_wr,
	output logic [15:0] o_io_addr,
	output logic [7:0] o_io_wdata,
	input wire logic i_io_trap,
	input wire logic i_win_hit
);
	initial
	begin
		o_cfg_wr = 1'b0;
		o_cfg_rd = 1'b0;
		o_cfg_addr = 8'hFF;
		o_cfg_be = 4'hF;
		o_cfg_wdata = 32'h0;
		o_io_valid = 1'b0;
		o_io_wr = 1'b0;
		o_io_addr = 16'hFFFF;
		o_io_wdata = 8'h00;
	end

	// released buses carry inverted data so stale values never look valid
	task automatic cfg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		o_cfg_wr <= 1'b1;
		o_cfg_addr <= a;
		o_cfg_wdata <= d;
		@(posedge i_clk);
		o_cfg_wr <= 1'b0;
		o_cfg_addr <= ~a;
		o_cfg_wdata <= ~d;
	endtask : cfg_write

	task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		o_cfg_rd <= 1'b1;
		o_cfg_addr <= a;
		@(posedge i_clk);
		o_cfg_rd <= 1'b0;
		o_cfg_addr <= ~a;
		#2;
		d = i_cfg_rdata;
	endtask : cfg_read

	task automatic io_access(input logic w, input logic [15:0] a, input logic [7:0] d,
		output logic t, output logic h);
		@(posedge i_clk);
		o_io_valid <= 1'b1;
		o_io_wr <= w;
		o_io_addr <= a;
		o_io_wdata <= d;
		#5;
		t = i_io_trap;
		h = i_win_hit;
		@(posedge i_clk);
		o_io_valid <= 1'b0;
		o_io_addr <= ~a;
		o_io_wdata <= ~d;
		// step off the edge so callers see registered outputs settled
		#1;
	endtask : io_access
endmodule : pci_host_model

// file: dv/tb.sv
/*
 * Self-checking bench for the USB function config and legacy trap block.
 * Assumes the host model in pci_host_model.sv and the design package.
 */
`timescale 1ns/1ns
`define CHK(got, exp) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) \
		begin \
			n_fail++; \
			$display("[FAIL] %0t got %h expected %h", $time, got, exp); \
		end \
	end
module tb
	import usb_cfg_pkg::*;
;
	logic i_clk, i_rst, i_ce, i_usb_irq, i_pirq;
	logic cfg_wr, cfg_rd, io_valid, io_wr, win_hit, io_trap, pirq_o, smi_n, clk_sel, gate;
	logic [7:0] cfg_addr, io_wdata;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata;
	logic [15:0] io_addr;
	int n_fail = 0;
	int tests_run = 0;

	usb_function_config usb_function_config_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
		.i_cfg_wr(cfg_wr), .i_cfg_rd(cfg_rd), .i_cfg_addr(cfg_addr), .i_cfg_be(cfg_be),
		.i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata), .i_io_valid(io_valid),
		.i_io_wr(io_wr), .i_io_addr(io_addr), .i_io_wdata(io_wdata), .o_usb_win_hit(win_hit),
		.o_io_trap(io_trap), .i_usb_irq(i_usb_irq), .i_shared_pci_irq_fourth(i_pirq),
		.o_shared_pci_irq_fourth(pirq_o), .o_sys_mgmt_irq_n(smi_n),
		.o_usb_clk_48m_sel(clk_sel), .o_addr_line20_gate(gate));

	pci_host_model pci_host_model_i (.i_clk(i_clk), .o_cfg_wr(cfg_wr), .o_cfg_rd(cfg_rd),
		.o_cfg_addr(cfg_addr), .o_cfg_be(cfg_be), .o_cfg_wdata(cfg_wdata),
		.i_cfg_rdata(cfg_rdata), .o_io_valid(io_valid), .o_io_wr(io_wr), .o_io_addr(io_addr),
		.o_io_wdata(io_wdata), .i_io_trap(io_trap), .i_win_hit(win_hit));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		pci_host_model_i.cfg_read(a, d);
		`CHK(d, e)
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		pci_host_model_i.cfg_write(a, d);
	endtask : wr

	task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d, input logic e);
		logic t, h;
		pci_host_model_i.io_access(w, a, d, t, h);
		`CHK(t, e)
	endtask : io

	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_clk);
		#2;
	endtask : wait_clk

	task automatic conclude;
		$display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_defaults;
		rd(BASE_OFS, 32'h00000001);
		rd(ILINE_OFS, 32'h00000400);
		rd(REL_OFS, 32'h00000000);
		rd(8'h68, 32'h00010000);
		rd(LEG_OFS, 32'h00002000);
		rd(8'h80, 32'h00000000);
		`CHK(clk_sel, 1'b1)
		`CHK(smi_n, 1'b1)
	endtask : t_defaults

	task automatic t_base;
		logic t, h;
		wr(BASE_OFS, 32'hFFFFFFFF);
		rd(BASE_OFS, 32'h0000FFE1);
		pci_host_model_i.io_access(1'b0, 16'hFFFC, 8'h00, t, h);
		`CHK(h, 1'b1)
		pci_host_model_i.io_access(1'b0, 16'hFFDC, 8'h00, t, h);
		`CHK(h, 1'b0)
	endtask : t_base

	task automatic t_line_clk;
		wr(ILINE_OFS, 32'hFFFFFFFF);
		rd(ILINE_OFS, 32'h000004FF);
		io(1'b0, DATA_PORT, 8'h00, 1'b0);
		wr(8'h68, 32'h00000000);
		wait_clk(2);
		`CHK(clk_sel, 1'b0)
		wr(8'h68, 32'h00010000);
		wait_clk(2);
		`CHK(clk_sel, 1'b1)
		wr(LEG_OFS, 32'h00002100);
	endtask : t_line_clk

	// a write strobed while the enable is low must not land
	task automatic t_ce;
		i_ce <= 1'b0;
		wr(8'h68, 32'h00000000);
		wait_clk(2);
		`CHK(clk_sel, 1'b1)
		i_ce <= 1'b1;
		rd(8'h68, 32'h00010000);
	endtask : t_ce

	// k: 0 data read, 1 data write, 2 cmd read, 3 cmd write
	task automatic t_traps;
		logic [15:0] a;
		logic [31:0] f, e;
		for (int k = 0; k < 4; k++)
		begin
			a = (k < 2) ? DATA_PORT : CMD_PORT;
			f = 32'h1 << (8 + k);
			e = 32'h1 << k;
			io(k[0], a, 8'h00, 1'b0);
			`CHK(smi_n, 1'b1)
			rd(LEG_OFS, 32'h2000 | f);
			wr(LEG_OFS, 32'h2000 | e);
			wait_clk(2);
			`CHK(smi_n, 1'b0)
			rd(LEG_OFS, 32'h2000 | f | e);
			io(k[0], a, 8'h00, 1'b1);
			wr(LEG_OFS, 32'h2000 | f);
			rd(LEG_OFS, 32'h00002000);
			`CHK(smi_n, 1'b1)
		end
	endtask : t_traps

	task automatic t_passthru;
		wr(LEG_OFS, 32'h000020AF);
		io(1'b1, CMD_PORT, CMD_GATE, 1'b0);
		io(1'b1, CMD_PORT, CMD_GATE, 1'b0);
		rd(LEG_OFS, 32'h000020EF);
		io(1'b1, DATA_PORT, 8'h02, 1'b0);
		io(1'b0, CMD_PORT, 8'h00, 1'b0);
		`CHK(smi_n, 1'b1)
		io(1'b1, CMD_PORT, CMD_END, 1'b0);
		wait_clk(3);
		rd(LEG_OFS, 32'h0000A0AF);
		`CHK(gate, 1'b1)
		`CHK(smi_n, 1'b0)
		wr(LEG_OFS, 32'h0000A0AF);
		rd(LEG_OFS, 32'h000020AF);
		wait_clk(2);
		`CHK(smi_n, 1'b1)
		io(1'b1, CMD_PORT, CMD_GATE, 1'b0);
		io(1'b0, DATA_PORT, 8'h00, 1'b1);
		rd(LEG_OFS, 32'h000021AF);
		wr(LEG_OFS, 32'h000021AF);
		io(1'b1, CMD_PORT, CMD_GATE, 1'b0);
		rd(LEG_OFS, 32'h000020EF);
		wr(LEG_OFS, 32'h0000208F);
		rd(LEG_OFS, 32'h0000208F);
	endtask : t_passthru

	task automatic t_usb_irq;
		wr(LEG_OFS, 32'h00002000);
		i_usb_irq <= 1'b1;
		wait_clk(3);
		`CHK(pirq_o, 1'b1)
		rd(LEG_OFS, 32'h00003000);
		`CHK(smi_n, 1'b1)
		wr(LEG_OFS, 32'h00001000);
		rd(LEG_OFS, 32'h00001000);
		wait_clk(2);
		`CHK(pirq_o, 1'b0)
		wr(LEG_OFS, 32'h00000010);
		wait_clk(2);
		`CHK(smi_n, 1'b0)
		i_usb_irq <= 1'b0;
		wait_clk(3);
		rd(LEG_OFS, 32'h00000010);
		`CHK(smi_n, 1'b1)
		i_pirq <= 1'b1;
		wait_clk(6);
		`CHK(pirq_o, 1'b1)
		i_pirq <= 1'b0;
		wait_clk(6);
		`CHK(pirq_o, 1'b0)
	endtask : t_usb_irq

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	initial
	begin
		i_rst = 1'b1;
		i_ce = 1'b1;
		i_usb_irq = 1'b0;
		i_pirq = 1'b0;
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		t_defaults();
		t_base();
		t_line_clk();
		t_ce();
		t_traps();
		t_passthru();
		t_usb_irq();
		conclude();
	end

	// whole run needs well under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge i_clk);
		n_fail++;
		conclude();
	end
endmodule : tb
